// ==== cmt_pkg.sv ====
/*
   Constants and types shared by the mailbox transmit block: register offsets,
   field positions, reset values and the scheduler state encoding.
   Assumes a 12-bit APB byte address and 32-bit data words.
*/
package cmt_pkg;

   localparam int          CMT_NUM_MBX   = 8;
   localparam int          CMT_IDX_W     = 3;
   localparam int          CMT_AW        = 12;
   localparam int          CMT_DW        = 32;

   // Global registers, byte addresses.
   localparam logic [11:0] CMT_ADDR_MODE = 12'h000;
   localparam logic [11:0] CMT_ADDR_IMR  = 12'h004;
   localparam logic [11:0] CMT_ADDR_TCR  = 12'h008;
   localparam logic [11:0] CMT_ADDR_ACR  = 12'h00C;
   localparam logic [11:0] CMT_ADDR_EVT  = 12'h010;

   // Mailbox m occupies 0x100 + 0x20*m; page is paddr[11:8], index paddr[7:5].
   localparam logic [3:0]  CMT_PAGE_GLB  = 4'h0;
   localparam logic [3:0]  CMT_PAGE_MBX  = 4'h1;
   localparam logic [4:0]  CMT_MB_MODE   = 5'h00;
   localparam logic [4:0]  CMT_MB_STAT   = 5'h04;
   localparam logic [4:0]  CMT_MB_CTRL   = 5'h08;
   localparam logic [4:0]  CMT_MB_DLO    = 5'h0C;
   localparam logic [4:0]  CMT_MB_DHI    = 5'h10;

   // Field positions.
   localparam int          CMT_RETRY_BIT = 0;
   localparam int          CMT_OT_LSB    = 24;
   localparam int          CMT_RANK_LSB  = 16;
   localparam int          CMT_ID_LSB    = 0;
   localparam int          CMT_LEN_LSB   = 16;
   localparam int          CMT_RTR_BIT   = 20;
   localparam int          CMT_PEND_BIT  = 21;
   localparam int          CMT_ABT_BIT   = 22;
   localparam int          CMT_RDY_BIT   = 23;
   localparam int          CMT_ABORT_BIT = 22;
   localparam int          CMT_XFER_BIT  = 23;

   localparam logic [2:0]  CMT_OT_TX     = 3'h3;
   localparam logic [31:0] CMT_RST_WORD  = 32'h0000_0000;

   typedef enum logic [2:0] {
      CMT_IDLE  = 3'b001,
      CMT_OFFER = 3'b010,
      CMT_SEND  = 3'b100
   } cmt_state_t;

endpackage : cmt_pkg

// ==== cmt_mbx_mem.sv ====
/*
   Mailbox data store: one write port and two registered read ports.
   Assumes a single clock; the array itself is not reset, only the read registers.
*/
`timescale 1ns/10ps
module cmt_mbx_mem #(
   parameter int AW    = 4,
   parameter int WORDS = 16
) (
   input  wire logic          clk_sys_in,
   input  wire logic          rst_n_in,
   input  wire logic          we_in,
   input  wire logic [AW-1:0] waddr_in,
   input  wire logic [31:0]   wdata_in,
   input  wire logic [AW-1:0] a_addr_in,
   output logic      [31:0]   a_data_out,
   input  wire logic [AW-1:0] b_addr_in,
   output logic      [31:0]   b_data_out
);

   logic [31:0] mem [WORDS];

   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         a_data_out <= 32'h0000_0000;
         b_data_out <= 32'h0000_0000;
      end else begin
         a_data_out <= mem[a_addr_in];
         b_data_out <= mem[b_addr_in];
      end
   end

endmodule : cmt_mbx_mem

// ==== cmt_mailbox_tx.sv ====
/*
   Transmit side of a CAN controller's mailboxes: APB registers, ready and abort
   bookkeeping, rank arbitration and an offer/send handshake with a protocol engine.
   Assumes a same-clock engine that starts only on an offer, then ends it once.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/10ps
module cmt_mailbox_tx #(
   parameter int NUM_MBX = cmt_pkg::CMT_NUM_MBX
) (
   input  wire logic                       clk_sys_in,
   input  wire logic                       rst_n_in,
   input  wire logic                       psel_in,
   input  wire logic                       penable_in,
   input  wire logic                       pwrite_in,
   input  wire logic [11:0]                paddr_in,
   input  wire logic [31:0]                pwdata_in,
   output logic      [31:0]                prdata_out,
   output logic                            pready_out,
   output logic                            pslverr_out,
   output logic                            irq_out,
   output logic                            tx_req_out,
   output logic      [cmt_pkg::CMT_IDX_W-1:0] tx_mbx_out,
   output logic      [10:0]                tx_id_out,
   output logic      [3:0]                 tx_len_out,
   output logic                            tx_rtr_out,
   output logic      [31:0]                tx_data_out,
   input  wire logic                       tx_word_in,
   input  wire logic                       tx_start_in,
   input  wire logic                       tx_done_in,
   input  wire logic                       tx_lost_in
);

   localparam int IW  = cmt_pkg::CMT_IDX_W;
   localparam int MAW = IW + 1;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);

   cmt_pkg::cmt_state_t    state;
   logic [IW-1:0]          cur;
   logic                   retry_dis;
   logic [NUM_MBX-1:0]     imr;
   logic [NUM_MBX-1:0]     evt;
   logic [NUM_MBX-1:0]     is_tx_v, ready_v, pend_v, abt_v, late_v, rtr_v;
   logic [NUM_MBX-1:0]     mode_wr_v, ctrl_wr_v, xfer_ok_v, abort_req_v, send_v;
   logic [NUM_MBX-1:0]     done_v, drop_v, cancel_v;
   logic [3:0]             rank_v [NUM_MBX];
   logic [3:0]             len_v  [NUM_MBX];
   logic [10:0]            id_v   [NUM_MBX];
   logic [IW-1:0]          win;
   logic                   found;
   logic [3:0]             best;
   logic                   acc1, wr_ok, glb_hit, mbx_hit, idx_ok, is_data, err_now;
   logic [IW-1:0]          mbx_idx;
   logic [4:0]             mbx_reg;
   logic [31:0]            rd_mux, mem_rdata;
   logic                   tcr_wr, acr_wr;

   // APB decode. The first access cycle computes the answer, the second ends it.
   assign acc1    = psel_in & penable_in & ~pready_out;
   assign wr_ok   = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
   assign glb_hit = paddr_in[11:8] == cmt_pkg::CMT_PAGE_GLB;
   assign mbx_hit = paddr_in[11:8] == cmt_pkg::CMT_PAGE_MBX;
   assign mbx_idx = paddr_in[7:5];
   assign mbx_reg = paddr_in[4:0];
   assign idx_ok  = int'(mbx_idx) < NUM_MBX;
   assign is_data = (mbx_reg == cmt_pkg::CMT_MB_DLO) | (mbx_reg == cmt_pkg::CMT_MB_DHI);
   assign tcr_wr  = wr_ok & (paddr_in == cmt_pkg::CMT_ADDR_TCR);
   assign acr_wr  = wr_ok & (paddr_in == cmt_pkg::CMT_ADDR_ACR);

   always_comb begin
      err_now = 1'b1;
      if (glb_hit) begin
         case (paddr_in)
            cmt_pkg::CMT_ADDR_MODE, cmt_pkg::CMT_ADDR_IMR, cmt_pkg::CMT_ADDR_TCR,
            cmt_pkg::CMT_ADDR_ACR, cmt_pkg::CMT_ADDR_EVT: err_now = 1'b0;
            default: err_now = 1'b1;
         endcase
      end else if (mbx_hit && idx_ok && paddr_in[1:0] == 2'h0 && mbx_reg <= cmt_pkg::CMT_MB_DHI) begin
         // Data words are locked away while the mailbox is busy.
         err_now = is_data & ~ready_v[mbx_idx];
      end
   end

   always_comb begin
      rd_mux = cmt_pkg::CMT_RST_WORD;
      if (glb_hit) begin
         case (paddr_in)
            cmt_pkg::CMT_ADDR_MODE: rd_mux[cmt_pkg::CMT_RETRY_BIT] = retry_dis;
            cmt_pkg::CMT_ADDR_IMR:  rd_mux[NUM_MBX-1:0] = imr;
            cmt_pkg::CMT_ADDR_EVT:  rd_mux[NUM_MBX-1:0] = evt;
            default:                rd_mux = cmt_pkg::CMT_RST_WORD;
         endcase
      end else if (idx_ok) begin
         case (mbx_reg)
            cmt_pkg::CMT_MB_MODE: begin
               rd_mux[cmt_pkg::CMT_OT_LSB +: 3]   = is_tx_v[mbx_idx] ? cmt_pkg::CMT_OT_TX : 3'h0;
               rd_mux[cmt_pkg::CMT_RANK_LSB +: 4] = rank_v[mbx_idx];
               rd_mux[cmt_pkg::CMT_ID_LSB +: 11]  = id_v[mbx_idx];
            end
            cmt_pkg::CMT_MB_STAT: begin
               rd_mux[cmt_pkg::CMT_RDY_BIT]      = ready_v[mbx_idx];
               rd_mux[cmt_pkg::CMT_ABT_BIT]      = abt_v[mbx_idx];
               rd_mux[cmt_pkg::CMT_PEND_BIT]     = pend_v[mbx_idx];
               rd_mux[cmt_pkg::CMT_RTR_BIT]      = rtr_v[mbx_idx];
               rd_mux[cmt_pkg::CMT_LEN_LSB +: 4] = len_v[mbx_idx];
            end
            cmt_pkg::CMT_MB_DLO, cmt_pkg::CMT_MB_DHI: rd_mux = mem_rdata;
            default: rd_mux = cmt_pkg::CMT_RST_WORD;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= cmt_pkg::CMT_RST_WORD;
      end else begin
         pready_out  <= acc1;
         pslverr_out <= acc1 & err_now;
         if (acc1) begin
            prdata_out <= (!pwrite_in && !err_now) ? rd_mux : cmt_pkg::CMT_RST_WORD;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         retry_dis <= 1'b0;
         imr       <= '0;
      end else if (wr_ok && paddr_in == cmt_pkg::CMT_ADDR_MODE) begin
         retry_dis <= pwdata_in[cmt_pkg::CMT_RETRY_BIT];
      end else if (wr_ok && paddr_in == cmt_pkg::CMT_ADDR_IMR) begin
         imr <= pwdata_in[NUM_MBX-1:0];
      end
   end

   // A completion in the same cycle as a write-one-to-clear keeps its bit set.
   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         evt <= '0;
      end else begin
         evt <= (evt & ~((wr_ok && paddr_in == cmt_pkg::CMT_ADDR_EVT) ? pwdata_in[NUM_MBX-1:0] : '0))
                | done_v | cancel_v;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(imr & (ready_v | evt));
      end
   end

   cmt_mbx_mem #(
      .AW    (MAW),
      .WORDS (2 * NUM_MBX)
   ) u_mem (
      .clk_sys_in (clk_sys_in),
      .rst_n_in   (rst_n_in),
      .we_in      (wr_ok & mbx_hit & is_data),
      .waddr_in   ({mbx_idx, mbx_reg == cmt_pkg::CMT_MB_DHI}),
      .wdata_in   (pwdata_in),
      .a_addr_in  ({mbx_idx, mbx_reg == cmt_pkg::CMT_MB_DHI}),
      .a_data_out (mem_rdata),
      .b_addr_in  ({cur, tx_word_in}),
      .b_data_out (tx_data_out)
   );

   genvar m;
   generate
      for (m = 0; m < NUM_MBX; m++) begin : g_mbx
         logic        is_tx, ready, pend, abt, late, rtr;
         logic [3:0]  rank, len;
         logic [10:0] id;
         logic        sel;

         assign sel            = mbx_hit & (mbx_idx == IW'(m));
         assign mode_wr_v[m]   = wr_ok & sel & (mbx_reg == cmt_pkg::CMT_MB_MODE);
         assign ctrl_wr_v[m]   = wr_ok & sel & (mbx_reg == cmt_pkg::CMT_MB_CTRL);
         assign xfer_ok_v[m]   = ((ctrl_wr_v[m] & pwdata_in[cmt_pkg::CMT_XFER_BIT]) | (tcr_wr & pwdata_in[m]))
                                 & is_tx & ready;
         assign abort_req_v[m] = (ctrl_wr_v[m] & pwdata_in[cmt_pkg::CMT_ABORT_BIT]) | (acr_wr & pwdata_in[m]);
         assign send_v[m]      = (cur == IW'(m)) & ((state == cmt_pkg::CMT_SEND)
                                 | (state == cmt_pkg::CMT_OFFER & tx_start_in));
         assign cancel_v[m]    = (abort_req_v[m] & pend & ~send_v[m]) | drop_v[m];
         assign {is_tx_v[m], ready_v[m], pend_v[m]} = {is_tx, ready, pend};
         assign {abt_v[m], late_v[m], rtr_v[m]}      = {abt, late, rtr};
         assign {rank_v[m], len_v[m], id_v[m]}       = {rank, len, id};

         always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in) begin
               is_tx <= 1'b0;
               ready <= 1'b0;
               pend  <= 1'b0;
               abt   <= 1'b0;
               late  <= 1'b0;
               rtr   <= 1'b0;
               rank  <= 4'h0;
               len   <= 4'h0;
               id    <= 11'h000;
            end else if (mode_wr_v[m]) begin
               // Rewriting the mode discards any queued frame of this mailbox.
               is_tx <= pwdata_in[cmt_pkg::CMT_OT_LSB +: 3] == cmt_pkg::CMT_OT_TX;
               ready <= pwdata_in[cmt_pkg::CMT_OT_LSB +: 3] == cmt_pkg::CMT_OT_TX;
               rank  <= pwdata_in[cmt_pkg::CMT_RANK_LSB +: 4];
               id    <= pwdata_in[cmt_pkg::CMT_ID_LSB +: 11];
               pend  <= 1'b0;
               abt   <= 1'b0;
               late  <= 1'b0;
            end else if (done_v[m]) begin
               ready <= 1'b1;
               pend  <= 1'b0;
               late  <= 1'b0;
            end else if (cancel_v[m]) begin
               ready <= 1'b1;
               abt   <= 1'b1;
               pend  <= 1'b0;
               late  <= 1'b0;
            end else if (xfer_ok_v[m]) begin
               ready <= 1'b0;
               pend  <= 1'b1;
               abt   <= 1'b0;
               if (ctrl_wr_v[m]) begin
                  len <= pwdata_in[cmt_pkg::CMT_LEN_LSB +: 4];
                  rtr <= pwdata_in[cmt_pkg::CMT_RTR_BIT];
               end
            end else if (abort_req_v[m] && send_v[m] && pend) begin
               late <= 1'b1;
            end
         end

         chk_cmd_clears_ready : assert property (xfer_ok_v[m] && !mode_wr_v[m] |=> !ready && pend)
            else $error("transfer command did not clear ready");
         chk_busy_not_ready : assert property (pend |-> !ready)
            else $error("ready set while message pending");
         chk_tx_mode_ready : assert property (mode_wr_v[m] && pwdata_in[cmt_pkg::CMT_OT_LSB +: 3]
                                              == cmt_pkg::CMT_OT_TX |=> ready && is_tx)
            else $error("transmit mode did not raise ready");
         chk_early_abort : assert property (abort_req_v[m] && pend && !send_v[m] && !mode_wr_v[m]
                                            |=> ready && abt)
            else $error("early abort did not set both flags");
         chk_late_abort : assert property (late && done_v[m] && !mode_wr_v[m] |=> ready && !abt)
            else $error("late abort reported as aborted");
         chk_abt_hold : assert property (abt && !xfer_ok_v[m] && !mode_wr_v[m] |=> abt)
            else $error("abort flag dropped before next transfer");
         chk_rank_order : assert property (state == cmt_pkg::CMT_IDLE && pend && |pend_v
                                           |-> rank_v[win] < rank || (rank_v[win] == rank && win <= IW'(m)))
            else $error("arbitration chose a less urgent mailbox");
      end
   endgenerate

   // Strict comparison in ascending order keeps the lower index on a tie.
   always_comb begin
      win   = '0;
      found = 1'b0;
      best  = 4'hF;
      for (int i = 0; i < NUM_MBX; i++) begin
         if (pend_v[i] && (!found || rank_v[i] < best)) begin
            win   = IW'(i);
            best  = rank_v[i];
            found = 1'b1;
         end
      end
   end

   always_comb begin
      done_v = '0;
      drop_v = '0;
      if (state == cmt_pkg::CMT_SEND) begin
         if (tx_done_in) begin
            done_v[cur] = 1'b1;
         end else if (tx_lost_in && (retry_dis || late_v[cur])) begin
            drop_v[cur] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!rst_n_in) begin
         state      <= cmt_pkg::CMT_IDLE;
         cur        <= '0;
         tx_req_out <= 1'b0;
         tx_id_out  <= 11'h000;
         tx_len_out <= 4'h0;
         tx_rtr_out <= 1'b0;
      end else begin
         case (state)
            cmt_pkg::CMT_IDLE: begin
               if (|pend_v) begin
                  cur        <= win;
                  tx_id_out  <= id_v[win];
                  tx_len_out <= len_v[win];
                  tx_rtr_out <= rtr_v[win];
                  tx_req_out <= 1'b1;
                  state      <= cmt_pkg::CMT_OFFER;
               end
            end
            cmt_pkg::CMT_OFFER: begin
               if (tx_start_in) begin
                  tx_req_out <= 1'b0;
                  state      <= cmt_pkg::CMT_SEND;
               end else if (!pend_v[cur] || win != cur) begin
                  // Withdraw the offer so a more urgent mailbox can compete.
                  tx_req_out <= 1'b0;
                  state      <= cmt_pkg::CMT_IDLE;
               end
            end
            cmt_pkg::CMT_SEND: begin
               // A lost frame stays pending and competes again from idle, unless retry_dis or a late abort drops it.
               if (tx_done_in || tx_lost_in) begin
                  state <= cmt_pkg::CMT_IDLE;
               end
            end
            default: begin
               tx_req_out <= 1'b0;
               state      <= cmt_pkg::CMT_IDLE;
            end
         endcase
      end
   end

   assign tx_mbx_out = cur;

   chk_retry_kept : assert property (state == cmt_pkg::CMT_SEND && tx_lost_in && !tx_done_in && !retry_dis
                                     && !late_v[cur] && !mode_wr_v[cur] |=> pend_v[$past(cur)])
      else $error("lost frame was not kept for retry");
   chk_no_retry : assert property (state == cmt_pkg::CMT_SEND && tx_lost_in && !tx_done_in && retry_dis
                                   && !mode_wr_v[cur] |=> abt_v[$past(cur)] && ready_v[$past(cur)])
      else $error("retry disabled but frame not aborted");
   chk_sent_ready : assert property (state == cmt_pkg::CMT_SEND && tx_done_in && !mode_wr_v[cur]
                                     |=> ready_v[$past(cur)] ##2 (irq_out || !imr[$past(cur, 3)]))
      else $error("sent mailbox not ready again");
   chk_irq_level : assert property (|(imr & ready_v) |=> irq_out)
      else $error("interrupt missing for ready mailbox");
   chk_remote_frame : assert property (state == cmt_pkg::CMT_IDLE && |pend_v
                                       |=> tx_req_out && tx_rtr_out == rtr_v[cur] && tx_mbx_out == $past(win))
      else $error("offered frame does not match winning mailbox");
   chk_data_lock : assert property (acc1 && mbx_hit && idx_ok && is_data && !ready_v[mbx_idx]
                                    |=> pready_out && pslverr_out)
      else $error("data access while busy was not refused");

   cov_sent : cover property (state == cmt_pkg::CMT_SEND && tx_done_in);
   cov_early_abort : cover property (|(cancel_v & ~drop_v));
   cov_late_abort : cover property (|(late_v & done_v));
   cov_retry : cover property (state == cmt_pkg::CMT_SEND && tx_lost_in && !retry_dis ##[1:20] tx_start_in);

endmodule : cmt_mailbox_tx

// ==== cmt_engine_model.sv ====
/*
   Behavioural protocol engine standing behind the mailbox transmit block.
   Assumes the block's same-clock offer, start, done and lost handshake.
*/
`timescale 1ns/10ps
module cmt_engine_model (
   input  wire logic clk_sys_in,
   input  wire logic rst_n_in,
   input  wire logic tx_req_in,
   input  wire logic stall_in,
   input  wire logic lose_in,
   input  wire logic slow_in,
   output logic      start_out,
   output logic      done_out,
   output logic      lost_out,
   output logic      word_out
);
   logic       busy;
   logic [5:0] cnt;

   // The word select toggles every cycle so that a stale value is never trusted.
   always_ff @(posedge clk_sys_in) begin
      start_out <= 1'b0;
      done_out  <= 1'b0;
      lost_out  <= 1'b0;
      word_out  <= rst_n_in ? ~word_out : 1'b0;
      if (!rst_n_in) begin
         busy     <= 1'b0;
      end else if (busy) begin
         cnt <= cnt - 6'h01;
         if (cnt == 6'h00) begin
            busy     <= 1'b0;
            lost_out <= lose_in;
            done_out <= ~lose_in;
         end
      end else if (tx_req_in && !stall_in) begin
         start_out <= 1'b1;
         busy      <= 1'b1;
         cnt       <= slow_in ? 6'h1E : 6'h03;
      end
   end
endmodule : cmt_engine_model

// ==== tb_can_mailbox_transmit.sv ====
/*
   Self-checking bench for the mailbox transmit block and its engine model.
   Assumes one APB master here and a 50 MHz clock.
*/
`timescale 1ns/10ps
module tb_can_mailbox_transmit;
   logic        clk, rst_n, psel, penable, pwrite, stall, lose, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rnd, txd;
   logic        pready, pslverr, irq, req, rtr, start, done, lost, word;
   logic [2:0]  mbx;
   logic [10:0] id;
   logic [3:0]  len;
   int          n_errors, samples_checked, n_start, n_end, n_lost, cyc;
   logic [33:0] rq[$];
   logic [18:0] fq[$];
   logic [3:0]  rk[4] = '{4'h9, 4'h4, 4'h1, 4'h1};

   cmt_mailbox_tx DUT (.clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .irq_out(irq), .tx_req_out(req), .tx_mbx_out(mbx), .tx_id_out(id),
      .tx_len_out(len), .tx_rtr_out(rtr), .tx_data_out(txd), .tx_word_in(word), .tx_start_in(start),
      .tx_done_in(done), .tx_lost_in(lost));
   cmt_engine_model ENG (.clk_sys_in(clk), .rst_n_in(rst_n), .tx_req_in(req), .stall_in(stall),
      .lose_in(lose), .slow_in(slow), .start_out(start), .done_out(done), .lost_out(lost), .word_out(word));

   task automatic summarize;
      if (n_errors == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
      rq.push_back({~w, err, d});
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
      apb(1'b0, a, e, err);
   endtask : rd

   // The interrupt is registered, so it is sampled mid-cycle after the write lands.
   task automatic chk_irq(input logic e);
      @(negedge clk);
      check("irq", irq, e);
      @(posedge clk);
   endtask : chk_irq

   function automatic logic [11:0] mb(input int m, input logic [4:0] r);
      return 12'h100 + 12'(m * 32) + {7'h00, r};
   endfunction : mb

   function automatic logic [18:0] fr(input int m, input logic r, input logic [3:0] l);
      return {3'(m), r, l, 3'(m), 8'hA5};
   endfunction : fr

   always @(posedge clk) begin
      if (rst_n === 1'b1 && pready === 1'b1) begin
         check("slverr", pslverr, rq[0][32]);
         if (rq[0][33]) check("rdata", prdata, rq[0][31:0]);
         void'(rq.pop_front());
      end
      if (start === 1'b1 && req === 1'b1) begin
         check("frame", {mbx, rtr, len, id}, fq.pop_front());
         n_start++;
      end
      if (done === 1'b1 || lost === 1'b1) n_end++;
      if (lost === 1'b1) n_lost++;
      if (done === 1'b1 && mbx === 3'h1) check("txdata", txd, word ? rnd : ~rnd);
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         summarize();
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      {rst_n, psel, penable, pwrite, stall, lose, slow} = '0;
      paddr  = '0;
      pwdata = '0;
      rnd    = $urandom(32'h4B86D54A);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0, 1'b0);
      rd(12'h014, 32'h0, 1'b1);
      rd(mb(0, cmt_pkg::CMT_MB_DLO), 32'h0, 1'b1);
      wr(cmt_pkg::CMT_ADDR_IMR, 32'h0F);
      for (int m = 0; m < 4; m++) wr(mb(m, 5'h00), {5'h00, cmt_pkg::CMT_OT_TX, 4'h0, rk[m], 5'h00, 3'(m), 8'hA5});
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0080_0000, 1'b0);
      chk_irq(1'b1);
      rnd = $urandom;
      wr(mb(1, cmt_pkg::CMT_MB_DLO), rnd);
      wr(mb(1, cmt_pkg::CMT_MB_DHI), ~rnd);
      rd(mb(1, cmt_pkg::CMT_MB_DLO), rnd, 1'b0);
      rd(mb(1, cmt_pkg::CMT_MB_DHI), ~rnd, 1'b0);
      stall <= 1'b1;
      fq = '{fr(2, 0, 3), fr(3, 1, 0), fr(1, 0, 8), fr(0, 0, 0)};
      wr(mb(1, cmt_pkg::CMT_MB_CTRL), 32'h0088_0000);
      wr(mb(2, cmt_pkg::CMT_MB_CTRL), 32'h0083_0000);
      wr(mb(3, cmt_pkg::CMT_MB_CTRL), 32'h0090_0000);
      wr(mb(0, cmt_pkg::CMT_MB_CTRL), 32'h0080_0000);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0020_0000, 1'b0);
      rd(mb(0, cmt_pkg::CMT_MB_DLO), 32'h0, 1'b1);
      chk_irq(1'b0);
      stall <= 1'b0;
      wait (n_end >= 4);
      rd(cmt_pkg::CMT_ADDR_EVT, 32'h0F, 1'b0);
      wr(cmt_pkg::CMT_ADDR_EVT, 32'h0F);
      rd(cmt_pkg::CMT_ADDR_EVT, 32'h0, 1'b0);
      chk_irq(1'b1);
      fq = '{fr(0, 0, 0), fr(0, 0, 0)};
      lose <= 1'b1;
      wr(mb(0, cmt_pkg::CMT_MB_CTRL), 32'h0080_0000);
      wait (n_lost >= 1);
      lose <= 1'b0;
      wait (n_end >= 6);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0080_0000, 1'b0);
      wr(cmt_pkg::CMT_ADDR_MODE, 32'h1);
      fq.push_back(fr(0, 0, 0));
      lose <= 1'b1;
      wr(mb(0, cmt_pkg::CMT_MB_CTRL), 32'h0080_0000);
      wait (n_end >= 7);
      lose <= 1'b0;
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h00C0_0000, 1'b0);
      wr(cmt_pkg::CMT_ADDR_MODE, 32'h0);
      stall <= 1'b1;
      wr(mb(0, cmt_pkg::CMT_MB_CTRL), 32'h0080_0000);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0020_0000, 1'b0);
      wr(cmt_pkg::CMT_ADDR_ACR, 32'h1);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h00C0_0000, 1'b0);
      stall <= 1'b0;
      slow  <= 1'b1;
      fq = '{fr(1, 0, 8), fr(0, 0, 0)};
      wr(cmt_pkg::CMT_ADDR_TCR, 32'h3);
      wait (n_start >= 9);
      wr(mb(0, cmt_pkg::CMT_MB_CTRL), 32'h0040_0000);
      wait (n_end >= 9);
      rd(mb(0, cmt_pkg::CMT_MB_STAT), 32'h0080_0000, 1'b0);
      summarize();
   end
endmodule : tb_can_mailbox_transmit
